// *** io_channel_unit.sv ***
// Channel service, input and output channels, control channels and downlink.
// Assumes processor bus signals share clk; every pin input is asynchronous.
`timescale 1ns/1ns
`default_nettype none

module iocu_fifo #(
    parameter int W = 30,
    parameter int D = 16
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Async reset, low
    input wire logic in_valid, // Push request
    output logic in_ready, // Room for a word
    input wire logic [W-1:0] in_data, // Pushed word
    output logic out_valid, // Word available
    input wire logic out_ready, // Pop request
    output logic [W-1:0] out_data // Oldest word
);
    localparam int PW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = cnt_r != (PW+1)'(D);
    assign out_valid = cnt_r != '0;
    assign out_data = mem[rp_r];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= push ? wp_r + 1'b1 : wp_r;
            rp_r <= pop ? rp_r + 1'b1 : rp_r;
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

// Notes on behaviour
// R1: channel address equals channel number
// R2: six inputs, nine outputs, plus channel 7
// R3: address is channel only for I/O instructions
// R4: channels 01, 02 reach accumulator, return register
// R5: input channels loaded from pins, never written
// R6: every channel is 15 bits wide
// R7: keyboard and mark inputs raise interrupts
// R8: channels 30 and 33 never interrupt; 31 and 32 only through the hand controller interrupt
// R9: channel 13 bits 1-4 drive radar, lander only
// R10: bit 5 blocks uplink, enables crosslink
// R11: external inhibit also blocks uplink
// R12: bit 6 blocks all serial inlink
// R13: bit 7 sets downlink word order
// R14: bit 8 passes incremental inputs as requests
// R15: bit 10 lights lamps, bit 11 permits standby
// R16: top bit enables sixth timer interrupt
// R17: bits 12-14 gate hand controller interrupt
// R18: output channels are readable, writable registers
// R19: channel 14 bit 11 drives counted pulse burst
// R20: channel 34/35 load interrupts; start begins readout
// R21: bit sync steps counter, decoded serial output
// R22: pulses and timing form write, clear, read gates
// R23: keyboard capture blocked until key release
// R24: inactive bits read zero, writes ignored
module io_channel_unit
    import iocu_pkg::*;
#(
    parameter bit LANDER = 1'b1 // Lander build uses channel 13 radar bits
) (
    input wire logic clk, // 125 MHz clock
    input wire logic rst_n, // Async reset, low
    input wire iocu_pkg::iocu_bus_t bus, // Processor channel request
    input wire logic [iocu_pkg::DW-1:0] lacc_in, // Lower accumulator value
    input wire logic [iocu_pkg::DW-1:0] ret_in, // Return register value
    input wire logic drive_ack, // Counter processed one decrement
    input wire logic drive_zero, // Counter reached zero
    input wire iocu_pkg::iocu_pins_t pins, // Asynchronous discrete pins
    output logic [iocu_pkg::DW-1:0] rd_data_r, // Channel read data
    output logic rd_valid_r, // Read data strobe
    output logic mem_access_r, // Address passed on as memory
    output logic [iocu_pkg::AW-1:0] mem_addr_r, // Memory address
    output logic [1:0] proc_write_r, // Write to accumulator, return reg
    output logic [iocu_pkg::DW-1:0] proc_wdata_r, // Data for that write
    output logic key_interrupt_one_r, // Keyboard interrupt pulse
    output logic key_interrupt_two_r, // Second keyboard interrupt pulse
    output logic mark_interrupt_r, // Mark interrupt pulse
    output logic hand_controller_interrupt_r, // Hand controller pulse
    output logic downlink_interrupt_r, // Downlink loaded pulse
    output logic uplink_data_r, // Gated uplink bit
    output logic crosslink_data_r, // Gated crosslink bit
    output logic [iocu_pkg::NUM_INCR-1:0] incr_request_r, // Counter requests
    output logic drive_request_r, // Drive counter service request
    output logic [iocu_pkg::AW-1:0] drive_addr_r, // Drive counter address
    output logic drive_pulse_r, // Drive pulse out
    output logic [3:0] radar_ctrl_r, // Radar control outputs
    output logic alarm_test_lamps_r, // Restart and standby lamps
    output logic standby_enable_r, // Standby permitted
    output logic sixth_timer_enable_r, // Sixth timer interrupt enable
    output logic downlink_serial_r, // Serial downlink bit
    output logic downlink_active_r, // Read flip-flop
    output logic downlink_space_r // Downlink buffer can take a word
);
    import iocu_pkg::*;

    iocu_pins_t pins_m_r;
    iocu_pins_t pins_s_r;
    iocu_pins_t pins_p_r;
    logic [DW-1:0] out_q [NUM_OUT];
    logic [DW-1:0] rd_or [NUM_OUT+1];
    logic [DW-1:0] key_r;
    logic [DW-1:0] mark_r;
    logic key_armed_r;
    logic mark_armed_r;
    logic hand_prev_r;
    logic drive_clear;
    logic [DL_BITS-1:0] dl_word_r;
    logic [4:0] dl_cnt_r;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [DL_BITS-1:0] fifo_out_data;

    // Pins pass two flops; the third copy only serves edge detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_m_r <= '0;
            pins_s_r <= '0;
            pins_p_r <= '0;
        end else begin
            pins_m_r <= pins;
            pins_s_r <= pins_m_r;
            pins_p_r <= pins_s_r;
        end
    end

    wire wr_gate = bus.io_instr && bus.chan_write_pulse && bus.write_timing; // [R22] [R3]
    wire clr_gate = bus.io_instr && bus.chan_write_pulse && bus.clear_timing; // [R22]
    wire rd_gate = bus.io_instr && bus.chan_read_pulse && bus.read_timing; // [R22]
    wire mem_gate = !bus.io_instr && (bus.chan_read_pulse || bus.chan_write_pulse)
        && bus.read_timing; // [R3]
    wire [DW-1:0] link = out_q[IDX_LINK];
    wire bitsync_e = pins_s_r.bit_sync && !pins_p_r.bit_sync;
    wire start_e = pins_s_r.downlink_start && !pins_p_r.downlink_start;
    wire [NUM_INCR-1:0] incr_e = pins_s_r.incr & ~pins_p_r.incr;
    wire dl_push = wr_gate && bus.addr == OUT_ADDR[IDX_DL_B];
    wire dl_pop = start_e && fifo_out_valid;
    wire hand_req = (link[B_HAND_A] && |pins_s_r.in31[5:0])
        || (link[B_HAND_B] && |pins_s_r.in31[DW-1:6])
        || (link[B_HAND_C] && |pins_s_r.in32); // [R17]

    // Output channel registers; a hardware clear applies only to the drive bit
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
            localparam logic [DW-1:0] MSK = (gi == IDX_LINK && !LANDER)
                ? (OUT_MASK[gi] & ~RADAR_MASK) : OUT_MASK[gi]; // [R9] [R24]
            wire hit = bus.addr == OUT_ADDR[gi]; // [R1] [R2]
            wire [DW-1:0] hw_clr = (gi == IDX_DRIVE && drive_clear)
                ? (DW)'(1) << B_DRIVE_EN : '0;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    out_q[gi] <= OUT_RESET;
                end else if (wr_gate && hit) begin
                    out_q[gi] <= bus.wdata & MSK; // [R18] [R6]
                end else if (clr_gate && hit) begin
                    out_q[gi] <= '0;
                end else begin
                    out_q[gi] <= out_q[gi] & ~hw_clr; // [R19]
                end
            end
            assign rd_or[gi+1] = rd_or[gi] | (hit ? out_q[gi] : '0);
        end
    endgenerate

    // Channel data is ORed onto the read lines, so an unmapped address reads zero
    wire [DW-1:0] rd_in =
        (bus.addr == CH_LACC ? lacc_in : '0)
        | (bus.addr == CH_RET ? ret_in : '0) // [R4]
        | (bus.addr == CH_KEY ? key_r : '0)
        | (bus.addr == CH_MARK ? mark_r : '0)
        | (bus.addr == CH_IN30 ? pins_s_r.in30 : '0) // [R8] [R5]
        | (bus.addr == CH_IN31 ? pins_s_r.in31 : '0)
        | (bus.addr == CH_IN32 ? pins_s_r.in32 : '0)
        | (bus.addr == CH_IN33 ? pins_s_r.in33 : '0);
    assign rd_or[0] = rd_in;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= '0;
            rd_valid_r <= 1'b0;
            mem_access_r <= 1'b0;
            mem_addr_r <= '0;
            proc_write_r <= 2'b00;
            proc_wdata_r <= '0;
        end else begin
            rd_data_r <= rd_gate ? rd_or[NUM_OUT] : rd_data_r; // [R22]
            rd_valid_r <= rd_gate;
            mem_access_r <= mem_gate; // [R3]
            mem_addr_r <= mem_gate ? bus.addr : mem_addr_r;
            proc_write_r <= {wr_gate && bus.addr == CH_RET,
                wr_gate && bus.addr == CH_LACC}; // [R4]
            proc_wdata_r <= wr_gate ? bus.wdata : proc_wdata_r;
        end
    end

    // Keyboard and mark channels: capture once, re-arm on release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            key_r <= '0;
            mark_r <= '0;
            key_armed_r <= 1'b1;
            mark_armed_r <= 1'b1;
            key_interrupt_one_r <= 1'b0;
            key_interrupt_two_r <= 1'b0;
            mark_interrupt_r <= 1'b0;
        end else begin
            key_interrupt_one_r <= key_armed_r && |pins_s_r.key_code; // [R7]
            key_interrupt_two_r <= mark_armed_r && |pins_s_r.mark[2:0];
            mark_interrupt_r <= mark_armed_r && !(|pins_s_r.mark[2:0])
                && |pins_s_r.mark[6:3];
            if (key_armed_r && |pins_s_r.key_code) begin
                key_r <= DW'(pins_s_r.key_code) & KEY_MASK; // [R23]
                key_armed_r <= 1'b0;
            end else if (!key_armed_r && pins_s_r.key_code == '0) begin
                key_r <= '0;
                key_armed_r <= 1'b1;
            end
            if (mark_armed_r && |pins_s_r.mark) begin
                mark_r <= DW'(pins_s_r.mark) & MARK_MASK;
                mark_armed_r <= 1'b0;
            end else if (!mark_armed_r && pins_s_r.mark == '0) begin
                mark_r <= '0;
                mark_armed_r <= 1'b1;
            end
        end
    end

    // Control channel effects and drive burst handshake
    assign drive_clear = drive_ack && drive_zero;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hand_prev_r <= 1'b0;
            hand_controller_interrupt_r <= 1'b0;
            uplink_data_r <= 1'b0;
            crosslink_data_r <= 1'b0;
            incr_request_r <= '0;
            drive_request_r <= 1'b0;
            drive_addr_r <= '0;
            drive_pulse_r <= 1'b0;
            radar_ctrl_r <= '0;
            alarm_test_lamps_r <= 1'b0;
            standby_enable_r <= 1'b0;
            sixth_timer_enable_r <= 1'b0;
        end else begin
            hand_prev_r <= hand_req;
            hand_controller_interrupt_r <= hand_req && !hand_prev_r; // [R17]
            uplink_data_r <= pins_s_r.uplink_bit && !link[B_CROSS_SEL]
                && !pins_s_r.uplink_inhibit && !link[B_INLINK_OFF]; // [R10] [R11] [R12]
            crosslink_data_r <= pins_s_r.crosslink_bit && link[B_CROSS_SEL]
                && !link[B_INLINK_OFF]; // [R10] [R12]
            incr_request_r <= link[B_INCR_EN] ? incr_e : '0; // [R14]
            drive_request_r <= out_q[IDX_DRIVE][B_DRIVE_EN] && !drive_ack; // [R19]
            drive_addr_r <= DRIVE_ADDR;
            drive_pulse_r <= drive_ack && !drive_zero;
            radar_ctrl_r <= link[3:0]; // [R9]
            alarm_test_lamps_r <= link[B_ALARM_TEST]; // [R15]
            standby_enable_r <= link[B_STANDBY_EN];
            sixth_timer_enable_r <= link[B_TIMER6_EN]; // [R16]
        end
    end

    // Each load of channel 35 queues the pair unless the buffer is full; a full buffer shows on downlink_space_r
    iocu_fifo #(.W(DL_BITS), .D(FIFO_DEPTH)) u_dl_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(dl_push),
        .in_ready(fifo_in_ready),
        .in_data({out_q[IDX_DL_A], bus.wdata & OUT_MASK[IDX_DL_B]}),
        .out_valid(fifo_out_valid),
        .out_ready(start_e),
        .out_data(fifo_out_data)
    );

    wire [DL_BITS-1:0] dl_ordered = link[B_WORD_ORDER]
        ? {fifo_out_data[DW-1:0], fifo_out_data[DL_BITS-1:DW]}
        : fifo_out_data; // [R13]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            downlink_interrupt_r <= 1'b0;
            downlink_space_r <= 1'b0;
            dl_word_r <= '0;
            dl_cnt_r <= '0;
            downlink_active_r <= 1'b0;
            downlink_serial_r <= 1'b0;
        end else begin
            downlink_interrupt_r <= dl_push && fifo_in_ready; // [R20]
            downlink_space_r <= fifo_in_ready;
            if (dl_pop) begin
                dl_word_r <= dl_ordered; // [R20]
                dl_cnt_r <= '0;
                downlink_active_r <= 1'b1;
            end else if (bitsync_e && downlink_active_r) begin
                downlink_serial_r <= dl_word_r[5'(DL_BITS - 1) - dl_cnt_r]; // [R21]
                dl_cnt_r <= dl_cnt_r + 5'h01;
                downlink_active_r <= dl_cnt_r != 5'(DL_BITS - 1);
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_read_gate;
        rd_gate |=> rd_valid_r && !mem_access_r;
    endproperty
    a_read_gate: assert property (p_read_gate) else $error("read gate lost"); // [R22]

    property p_mem_addr;
        mem_gate |=> mem_access_r && !rd_valid_r && mem_addr_r == $past(bus.addr);
    endproperty
    a_mem_addr: assert property (p_mem_addr) else $error("memory address misrouted"); // [R3]

    property p_input_no_write;
        wr_gate && bus.addr == CH_KEY && !key_armed_r && pins_s_r.key_code != '0
            |=> $stable(key_r);
    endproperty
    a_input_no_write: assert property (p_input_no_write) else $error("input written"); // [R5]

    property p_uplink_block;
        (link[B_CROSS_SEL] || pins_s_r.uplink_inhibit) |=> !uplink_data_r;
    endproperty
    a_uplink_block: assert property (p_uplink_block) else $error("uplink passed"); // [R10]

    property p_inlink_block;
        link[B_INLINK_OFF] |=> !uplink_data_r && !crosslink_data_r;
    endproperty
    a_inlink_block: assert property (p_inlink_block) else $error("inlink passed"); // [R12]

    property p_incr_gate;
        !link[B_INCR_EN] |=> incr_request_r == '0;
    endproperty
    a_incr_gate: assert property (p_incr_gate) else $error("increment passed"); // [R14]

    property p_key_block;
        key_interrupt_one_r |-> !key_armed_r ##1 !key_interrupt_one_r;
    endproperty
    a_key_block: assert property (p_key_block) else $error("second keycode taken"); // [R23]

    property p_dl_irq;
        dl_push && fifo_in_ready |=> downlink_interrupt_r ##1 !downlink_interrupt_r;
    endproperty
    a_dl_irq: assert property (p_dl_irq) else $error("downlink interrupt missing"); // [R20]

    property p_drive_stop;
        drive_clear && !(wr_gate && bus.addr == OUT_ADDR[IDX_DRIVE])
            |=> !out_q[IDX_DRIVE][B_DRIVE_EN] ##1 !drive_request_r;
    endproperty
    a_drive_stop: assert property (p_drive_stop) else $error("drive burst not stopped"); // [R19]

endmodule

`default_nettype wire

// *** iocu_pkg.sv ***
// Shared constants and carriers for the input-output channel unit.
// Assumes channel addresses are three octal digits carried as a 9-bit field.
package iocu_pkg;

    localparam int DW = 15;
    localparam int AW = 9;

    // Addresses equal channel numbers; octal values written in hex
    localparam logic [AW-1:0] CH_LACC = 9'h001;
    localparam logic [AW-1:0] CH_RET = 9'h002;
    localparam logic [AW-1:0] CH_KEY = 9'h00D;
    localparam logic [AW-1:0] CH_MARK = 9'h00E;
    localparam logic [AW-1:0] CH_IN30 = 9'h018;
    localparam logic [AW-1:0] CH_IN31 = 9'h019;
    localparam logic [AW-1:0] CH_IN32 = 9'h01A;
    localparam logic [AW-1:0] CH_IN33 = 9'h01B;
    localparam logic [AW-1:0] DRIVE_ADDR = 9'h02C;

    // Output channels 5, 6, 7, 10, 11, 12, 13, 14, 34, 35
    localparam int NUM_OUT = 10;
    localparam logic [AW-1:0] OUT_ADDR [NUM_OUT] = '{
        9'h005, 9'h006, 9'h007, 9'h008, 9'h009, 9'h00A, 9'h00B, 9'h00C, 9'h01C, 9'h01D};
    localparam logic [DW-1:0] OUT_MASK [NUM_OUT] = '{
        15'h7FFF, 15'h7FFF, 15'h7FFF, 15'h7FFF, 15'h7FFF, 15'h7FFF, 15'h7EFF, 15'h7FFF,
        15'h7FFF, 15'h7FFF};
    localparam logic [DW-1:0] OUT_RESET = 15'h0000;
    localparam int IDX_LINK = 6;
    localparam int IDX_DRIVE = 7;
    localparam int IDX_DL_A = 8;
    localparam int IDX_DL_B = 9;

    localparam logic [DW-1:0] KEY_MASK = 15'h001F;
    localparam logic [DW-1:0] MARK_MASK = 15'h007F;
    localparam logic [DW-1:0] RADAR_MASK = 15'h000F;

    // Bit positions (bit n of a channel sits at index n-1)
    localparam int B_RADAR_LO = 0;
    localparam int B_CROSS_SEL = 4;
    localparam int B_INLINK_OFF = 5;
    localparam int B_WORD_ORDER = 6;
    localparam int B_INCR_EN = 7;
    localparam int B_ALARM_TEST = 9;
    localparam int B_STANDBY_EN = 10;
    localparam int B_HAND_A = 11;
    localparam int B_HAND_B = 12;
    localparam int B_HAND_C = 13;
    localparam int B_TIMER6_EN = 14;
    localparam int B_DRIVE_EN = 10;

    localparam int NUM_INCR = 6;
    localparam int DL_BITS = 2 * DW;
    localparam int FIFO_DEPTH = 16;

    typedef struct packed {
        logic io_instr;
        logic chan_write_pulse;
        logic chan_read_pulse;
        logic write_timing;
        logic clear_timing;
        logic read_timing;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } iocu_bus_t;

    typedef struct packed {
        logic [4:0] key_code;
        logic [6:0] mark;
        logic [DW-1:0] in30;
        logic [DW-1:0] in31;
        logic [DW-1:0] in32;
        logic [DW-1:0] in33;
        logic uplink_inhibit;
        logic uplink_bit;
        logic crosslink_bit;
        logic [NUM_INCR-1:0] incr;
        logic bit_sync;
        logic downlink_start;
    } iocu_pins_t;

endpackage

// *** iocu_proc_model.sv ***
// Processor-side model: issues channel instructions and services the drive counter.
// Assumes one clock shared with the channel unit; requests change 1 ns after an edge.
`timescale 1ns/1ns
`default_nettype none
module iocu_proc_model
    import iocu_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic drive_request_r, // Drive counter service request
    output var iocu_pkg::iocu_bus_t bus, // Channel instruction
    output logic drive_ack, // One decrement processed
    output logic drive_zero // Counter already at zero
);
    import iocu_pkg::*;
    int count = 0; // Counter preloaded by program
    int stall = 0; // Extra cycles before each service
    // Request stands across exactly one taking edge
    task automatic chan(input bit io, input bit wr, input logic [AW-1:0] a,
                        input logic [DW-1:0] d);
        @(posedge clk);
        #1;
        bus = {io, wr, !wr, wr, 1'b0, !wr, a, d};
        @(posedge clk);
        #1;
        // Released strobes drop to zero; address and data lines never keep the last value
        bus = {6'b000000, ~a, ~d};
    endtask
    initial begin
        bus = '0;
        drive_ack = 1'b0;
        drive_zero = 1'b0;
        forever begin
            @(posedge clk);
            if (drive_request_r === 1'b1) begin
                repeat (stall) @(posedge clk);
                #1;
                drive_zero = (count == 0);
                drive_ack = 1'b1;
                if (count > 0) count--;
                @(posedge clk);
                #1;
                drive_ack = 1'b0;
                drive_zero = !drive_zero;
                @(posedge clk);
            end
        end
    end
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the channel unit beside a processor-side model.
// Assumes the model drives bus and drive handshake; the bench drives the pins.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module tb;
    import iocu_pkg::*;
    typedef struct {logic [AW-1:0] a; logic [DW-1:0] d; logic [DW-1:0] e;} iocu_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    iocu_bus_t bus;
    iocu_pins_t pins = '0;
    logic [DW-1:0] lacc_in = 15'h1357;
    logic [DW-1:0] ret_in = 15'h2468;
    logic drive_ack, drive_zero, rd_valid_r, mem_access_r, key_interrupt_one_r;
    logic key_interrupt_two_r, mark_interrupt_r, hand_controller_interrupt_r;
    logic downlink_interrupt_r, uplink_data_r, crosslink_data_r, drive_request_r;
    logic drive_pulse_r, alarm_test_lamps_r, standby_enable_r, sixth_timer_enable_r;
    logic downlink_serial_r, downlink_active_r, downlink_space_r;
    logic [DW-1:0] rd_data_r, proc_wdata_r;
    logic [AW-1:0] mem_addr_r, drive_addr_r;
    logic [1:0] proc_write_r;
    logic [NUM_INCR-1:0] incr_request_r;
    logic [3:0] radar_ctrl_r;
    logic [6:0] seen = '0;
    wire logic [6:0] ev;
    int n_fail = 0;
    int num_checks = 0;
    int n_pulse = 0;
    int cyc = 0;
    iocu_row_t rows [12] = '{'{9'h005, 15'h7FFF, 15'h7FFF}, '{9'h006, 15'h1234, 15'h1234},
        '{9'h007, 15'h0ABC, 15'h0ABC}, '{9'h008, 15'h5555, 15'h5555},
        '{9'h009, 15'h2AAA, 15'h2AAA}, '{9'h00A, 15'h7FFF, 15'h7FFF},
        '{9'h00B, 15'h7FFF, 15'h7EFF}, '{9'h00C, 15'h0000, 15'h0000},
        '{9'h01C, 15'h4321, 15'h4321}, '{9'h018, 15'h7FFF, 15'h0F0F},
        '{9'h019, 15'h7FFF, 15'h0000}, '{9'h040, 15'h7FFF, 15'h0000}};
    logic [DW-1:0] ctl [2] = '{15'h460F, 15'h0000};
    assign ev = {key_interrupt_one_r, key_interrupt_two_r, mark_interrupt_r,
        hand_controller_interrupt_r, downlink_interrupt_r, |incr_request_r, downlink_active_r};
    io_channel_unit #(.LANDER(1'b1)) i_io_channel_unit (.clk, .rst_n, .bus, .lacc_in,
        .ret_in, .drive_ack, .drive_zero, .pins, .rd_data_r, .rd_valid_r, .mem_access_r,
        .mem_addr_r, .proc_write_r, .proc_wdata_r, .key_interrupt_one_r, .key_interrupt_two_r,
        .mark_interrupt_r, .hand_controller_interrupt_r, .downlink_interrupt_r,
        .uplink_data_r, .crosslink_data_r, .incr_request_r, .drive_request_r, .drive_addr_r,
        .drive_pulse_r, .radar_ctrl_r, .alarm_test_lamps_r, .standby_enable_r,
        .sixth_timer_enable_r, .downlink_serial_r, .downlink_active_r, .downlink_space_r);
    iocu_proc_model i_iocu_proc_model (.clk, .drive_request_r, .bus, .drive_ack, .drive_zero);
    initial begin
        forever #4 clk = ~clk;
    end
    // Sticky record of one-cycle pulses and the read flip-flop, cleared by the sequence
    always @(posedge clk) begin
        seen <= seen | ev;
        if (drive_pulse_r === 1'b1) n_pulse++;
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        i_iocu_proc_model.chan(1'b1, 1'b1, a, d);
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e, input string nm);
        i_iocu_proc_model.chan(1'b1, 1'b0, a, '0);
        `CHK(nm, {1'b1, e}, {rd_valid_r, rd_data_r})
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Edge on an edge-sensitive pin: 4 cycles high, 3 low
    task automatic tick(input int k);
        if (k == 0) pins.incr[0] = 1'b1;
        else if (k == 1) pins.bit_sync = 1'b1;
        else pins.downlink_start = 1'b1;
        w(4);
        pins.incr[0] = 1'b0;
        pins.bit_sync = 1'b0;
        pins.downlink_start = 1'b0;
        w(3);
    endtask
    initial begin
        logic [6:0] x7, g7;
        logic [DW-1:0] w34, w35;
        logic [29:0] dw;
        pins.in30 = 15'h0F0F;
        pins.uplink_bit = 1'b1;
        pins.crosslink_bit = 1'b1;
        w(4);
        rst_n = 1'b1;
        w(1);
        `CHK("rst", {9'h02C, 2'b10}, {drive_addr_r, downlink_space_r, rd_valid_r})
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e, "row");
        end
        wr(CH_RET, 15'h0555);
        `CHK("retw", {2'b10, 15'h0555}, {proc_write_r, proc_wdata_r})
        rd(CH_LACC, lacc_in, "lacc");
        i_iocu_proc_model.chan(1'b0, 1'b0, 9'h00B, '0);
        `CHK("mem", {2'b10, 9'h00B}, {mem_access_r, rd_valid_r, mem_addr_r})
        foreach (ctl[i]) begin
            wr(9'h00B, ctl[i]);
            w(2);
            x7 = {ctl[i][3:0], ctl[i][9], ctl[i][10], ctl[i][14]};
            g7 = {radar_ctrl_r, alarm_test_lamps_r, standby_enable_r, sixth_timer_enable_r};
            `CHK("ctl", x7, g7)
        end
        for (int k = 0; k < 8; k++) begin
            wr(9'h00B, {9'h000, k[1], k[0], 4'h0});
            pins.uplink_inhibit = k[2];
            w(5);
            x7 = {5'h00, !k[0] && !k[1] && !k[2], k[0] && !k[1]};
            `CHK("inlink", x7[1:0], {uplink_data_r, crosslink_data_r})
        end
        for (int e = 0; e < 2; e++) begin
            wr(9'h00B, e[0] ? 15'h0880 : 15'h0000);
            seen = '0;
            tick(0);
            pins.in31[0] = 1'b1;
            pins.in30 = ~pins.in30;
            w(6);
            g7 = {seen[6:3], 2'b00, seen[1]};
            `CHK("incr_hand", {3'b000, e[0], 2'b00, e[0]}, g7)
            pins.in31[0] = 1'b0;
        end
        seen = '0;
        pins.key_code = 5'h0A;
        w(6);
        `CHK("key", 1'b1, seen[6])
        rd(CH_KEY, 15'h000A, "ch15");
        seen = '0;
        pins.key_code = 5'h03;
        w(6);
        `CHK("keyhold", 1'b0, seen[6])
        // A processor write to a held input channel must not disturb it
        wr(CH_KEY, 15'h7FFF);
        rd(CH_KEY, 15'h000A, "ch15hold");
        pins.key_code = 5'h00;
        w(6);
        rd(CH_KEY, 15'h0000, "ch15clr");
        seen = '0;
        pins.key_code = 5'h11;
        w(6);
        `CHK("key2nd", 1'b1, seen[6])
        rd(CH_KEY, 15'h0011, "ch15b");
        pins.key_code = 5'h00;
        seen = '0;
        pins.mark = 7'h01;
        w(6);
        `CHK("keytwo", 2'b10, seen[5:4])
        rd(CH_MARK, 15'h0001, "ch16");
        pins.mark = 7'h00;
        w(6);
        seen = '0;
        pins.mark = 7'h08;
        w(6);
        `CHK("mark", 2'b01, seen[5:4])
        pins.mark = 7'h00;
        i_iocu_proc_model.count = 3;
        i_iocu_proc_model.stall = 2;
        n_pulse = 0;
        wr(9'h00C, 15'h0400);
        w(60);
        `CHK("pulses", 3, n_pulse)
        `CHK("drvreq", 1'b0, drive_request_r)
        rd(9'h00C, 15'h0000, "ch14");
        // Fill the buffer to refusal, then drain it frame by frame
        for (int i = 0; i < 16; i++) begin
            wr(9'h01C, {i[3:0], 11'h5A3});
            wr(9'h01D, {11'h2C6, i[3:0]});
            `CHK("dlint", 1'b1, downlink_interrupt_r)
        end
        w(1);
        `CHK("full", 1'b0, downlink_space_r)
        wr(9'h01D, 15'h7FFF);
        `CHK("dlfull", 1'b0, downlink_interrupt_r)
        for (int i = 0; i < 16; i++) begin
            wr(9'h00B, {8'h00, i[0], 6'h00});
            w34 = {i[3:0], 11'h5A3};
            w35 = {11'h2C6, i[3:0]};
            dw = i[0] ? {w35, w34} : {w34, w35};
            tick(2);
            `CHK("act", 1'b1, downlink_active_r)
            for (int b = 29; b >= 0; b--) begin
                tick(1);
                `CHK("ser", dw[b], downlink_serial_r)
            end
            `CHK("actend", 1'b0, downlink_active_r)
        end
        tick(2);
        `CHK("empty", 2'b01, {downlink_active_r, downlink_space_r})
        wr(9'h005, 15'h7FFF);
        rst_n = 1'b0;
        w(1);
        rst_n = 1'b1;
        rd(9'h005, 15'h0000, "rstch");
        stop_test();
    end
endmodule
`default_nettype wire
